//--- common/plcs_pkg.sv
// Constants shared by the link control and status register block.
package plcs_pkg;
  localparam logic [7:0] LINK_STATUS_OFFSET = 8'hd0;
  localparam int CPM_EN_BIT = 8;
  localparam int HAW_DIS_BIT = 9;
  localparam int BWM_IE_BIT = 10;
  localparam int ABW_IE_BIT = 11;
  localparam int RSVD_LO = 12;
  localparam int RSVD_HI = 15;
  localparam int SPEED_LO = 16;
  localparam int SPEED_HI = 19;
  localparam int WIDTH_LO = 20;
  localparam int WIDTH_HI = 25;
  localparam int TRAIN_ERR_BIT = 26;
  localparam int TRAINING_BIT = 27;
  localparam int SLOT_CLK_BIT = 28;
  localparam int DLL_ACT_BIT = 29;
  localparam int BWM_ST_BIT = 30;
  localparam int ABW_ST_BIT = 31;
  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [3:0] SPEED_5G0 = 4'h2;
  localparam logic [3:0] SPEED_RST = 4'h2;
  localparam logic [5:0] WIDTH_RST_UP = 6'h04;
  localparam logic [5:0] WIDTH_RST_DN = 6'h02;
  localparam logic TRAINING_RST = 1'b1;
  localparam logic SLOT_CLK_RST = 1'b1;
endpackage

//--- hdl/plcs_regs.sv
// Upper link control and link status register word of one switch port.
`timescale 1ns/1ps
// What this block does
// RULE1: Clock request pin is held unless clock power management enable is set.
// RULE2: Clock power management enable is zero and unwritable on downstream ports.
// RULE3: Hardware autonomous width disable is read-write, resetting to zero.
// RULE4: Bandwidth interrupt enables are read-only upstream, read-write downstream.
// RULE5: Link control bits 15 to 12 are reserved, preserved, without function.
// RULE6: Link speed field reports negotiated rate and resets to 5.0 Gb/s.
// RULE7: Width field reports lanes; resets to four upstream, two downstream.
// RULE8: Training error sets on failure, clears on reaching L0, resets zero.
// RULE9: Link training reads one during training, clears after, resets one.
// RULE10: Slot clock bit shows reference clock use; default loadable, resets one.
// RULE11: Bit 29 mirrors the link layer active state, resetting to zero.
// RULE12: Bandwidth status bits reset zero; writing one clears, zero keeps.
module plcs_regs #(
  parameter bit IS_DOWNSTREAM = 1'b0 // Port role strap.
) (
  input wire logic clock, // 200 MHz core clock.
  input wire logic resetn, // Asynchronous active-low reset.
  input wire logic cfg_wr, // Configuration write strobe.
  input wire logic cfg_rd, // Configuration read strobe.
  input wire logic [7:0] cfg_addr, // Configuration byte address.
  input wire logic [31:0] cfg_wdata, // Write data.
  input wire logic [3:0] cfg_be, // Write byte enables.
  output logic [31:0] cfg_rdata, // Read data, registered.
  input wire logic [3:0] link_speed, // Negotiated rate from training.
  input wire logic [5:0] link_width, // Negotiated lane count.
  input wire logic link_up, // Negotiated values are valid.
  input wire logic train_fail, // Training failed pulse.
  input wire logic train_l0, // Trained to L0 pulse.
  input wire logic train_active, // Training in progress level.
  input wire logic link_layer_active_state, // Link layer active level.
  input wire logic bw_mgmt_event, // Bandwidth management event pulse.
  input wire logic bw_auto_event, // Autonomous bandwidth event pulse.
  input wire logic slot_clk_load, // Default load strobe.
  input wire logic slot_clk_value, // Value to load.
  output logic clock_request_pin_hold, // Clock request must stay asserted.
  output logic hw_width_disable, // Autonomous width change disabled.
  output logic bw_mgmt_int_en, // Bandwidth management interrupt enable.
  output logic bw_auto_int_en // Autonomous bandwidth interrupt enable.
);
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  localparam logic [5:0] WIDTH_RST =
    IS_DOWNSTREAM ? plcs_pkg::WIDTH_RST_DN : plcs_pkg::WIDTH_RST_UP;

  logic cpm_q, cpm_d, haw_q, haw_d, bie_q, bie_d, aie_q, aie_d;
  logic [3:0] rsvd_q, rsvd_d, spd_q, spd_d;
  logic [5:0] wid_q, wid_d;
  logic terr_q, terr_d, trn_q, trn_d, sclk_q, sclk_d, dll_q, dll_d;
  logic bst_q, bst_d, ast_q, ast_d;
  logic [31:0] rdata_q, rdata_d, word;
  logic hit_wr, wr_b1, wr_b3;

  assign hit_wr = cfg_wr && (cfg_addr == plcs_pkg::LINK_STATUS_OFFSET);
  assign wr_b1 = hit_wr && cfg_be[1];
  assign wr_b3 = hit_wr && cfg_be[3];

  always_comb begin
    word = 32'h0000_0000;
    word[plcs_pkg::CPM_EN_BIT] = cpm_q;
    word[plcs_pkg::HAW_DIS_BIT] = haw_q;
    word[plcs_pkg::BWM_IE_BIT] = bie_q;
    word[plcs_pkg::ABW_IE_BIT] = aie_q;
    word[plcs_pkg::RSVD_HI:plcs_pkg::RSVD_LO] = rsvd_q;
    word[plcs_pkg::SPEED_HI:plcs_pkg::SPEED_LO] = spd_q;
    word[plcs_pkg::WIDTH_HI:plcs_pkg::WIDTH_LO] = wid_q;
    word[plcs_pkg::TRAIN_ERR_BIT] = terr_q;
    word[plcs_pkg::TRAINING_BIT] = trn_q;
    word[plcs_pkg::SLOT_CLK_BIT] = sclk_q;
    word[plcs_pkg::DLL_ACT_BIT] = dll_q;
    word[plcs_pkg::BWM_ST_BIT] = bst_q;
    word[plcs_pkg::ABW_ST_BIT] = ast_q;
  end

  always_comb begin
    cpm_d = cpm_q;
    haw_d = haw_q;
    bie_d = bie_q;
    aie_d = aie_q;
    rsvd_d = rsvd_q;
    spd_d = spd_q;
    wid_d = wid_q;
    if (wr_b1) begin
      // Downstream keeps the bit at zero; no store ever happens there.
      if (!IS_DOWNSTREAM) cpm_d = cfg_wdata[plcs_pkg::CPM_EN_BIT]; // RULE2
      haw_d = cfg_wdata[plcs_pkg::HAW_DIS_BIT]; // RULE3
      if (IS_DOWNSTREAM) begin
        bie_d = cfg_wdata[plcs_pkg::BWM_IE_BIT]; // RULE4
        aie_d = cfg_wdata[plcs_pkg::ABW_IE_BIT]; // RULE4
      end
      // Software preserves these; stored only so a read-back matches.
      rsvd_d = cfg_wdata[plcs_pkg::RSVD_HI:plcs_pkg::RSVD_LO]; // RULE5
    end
    if (link_up) begin
      spd_d = link_speed; // RULE6
      wid_d = link_width; // RULE7
    end
    terr_d = terr_q;
    if (train_fail) terr_d = 1'b1; // RULE8
    else if (train_l0) terr_d = 1'b0; // RULE8
    trn_d = train_active; // RULE9
    sclk_d = slot_clk_load ? slot_clk_value : sclk_q; // RULE10
    dll_d = link_layer_active_state; // RULE11
    // A new event wins over a clear in the same cycle.
    bst_d = bw_mgmt_event |
      (bst_q & ~(wr_b3 & cfg_wdata[plcs_pkg::BWM_ST_BIT])); // RULE12
    ast_d = bw_auto_event |
      (ast_q & ~(wr_b3 & cfg_wdata[plcs_pkg::ABW_ST_BIT])); // RULE12
    rdata_d = 32'h0000_0000;
    if (cfg_rd && cfg_addr == plcs_pkg::LINK_STATUS_OFFSET) rdata_d = word;
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cpm_q <= 1'b0;
      haw_q <= 1'b0;
      bie_q <= 1'b0;
      aie_q <= 1'b0;
      rsvd_q <= 4'h0;
      spd_q <= plcs_pkg::SPEED_RST;
      wid_q <= WIDTH_RST;
      terr_q <= 1'b0;
      trn_q <= plcs_pkg::TRAINING_RST;
      sclk_q <= plcs_pkg::SLOT_CLK_RST;
      dll_q <= 1'b0;
      bst_q <= 1'b0;
      ast_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      cpm_q <= cpm_d;
      haw_q <= haw_d;
      bie_q <= bie_d;
      aie_q <= aie_d;
      rsvd_q <= rsvd_d;
      spd_q <= spd_d;
      wid_q <= wid_d;
      terr_q <= terr_d;
      trn_q <= trn_d;
      sclk_q <= sclk_d;
      dll_q <= dll_d;
      bst_q <= bst_d;
      ast_q <= ast_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata = rdata_q;
  assign clock_request_pin_hold = ~cpm_q; // RULE1
  assign hw_width_disable = haw_q;
  assign bw_mgmt_int_en = bie_q;
  assign bw_auto_int_en = aie_q;

  // All checks run on the core clock and sleep while the internal reset
  // copy is low.
  default clocking cb_core @(posedge clock);
  endclocking
  default disable iff (!rst_n_q);

  // Level edges on the training and link layer pins.
  sequence s_train_begin;
    !train_active ##1 train_active;
  endsequence
  sequence s_train_finish;
    train_active ##1 !train_active;
  endsequence
  sequence s_dll_rise;
    !link_layer_active_state ##1 link_layer_active_state;
  endsequence
  sequence s_dll_fall;
    link_layer_active_state ##1 !link_layer_active_state;
  endsequence
  // Write-one clears that no new event overtakes, and the status register read.
  sequence s_mgmt_clear;
    wr_b3 && cfg_wdata[plcs_pkg::BWM_ST_BIT] && !bw_mgmt_event;
  endsequence
  sequence s_auto_clear;
    wr_b3 && cfg_wdata[plcs_pkg::ABW_ST_BIT] && !bw_auto_event;
  endsequence
  sequence s_status_read;
    cfg_rd && cfg_addr == plcs_pkg::LINK_STATUS_OFFSET;
  endsequence

  a_cpm_write: assert property (!IS_DOWNSTREAM && wr_b1 |=> // RULE1
    clock_request_pin_hold == !$past(cfg_wdata[plcs_pkg::CPM_EN_BIT]))
    else $error("clock request hold does not follow enable write");

  a_cpm_steady: assert property (!wr_b1 |=> // RULE1
    $stable(clock_request_pin_hold))
    else $error("clock request hold moved without write");

  a_cpm_out_down: assert property (IS_DOWNSTREAM |-> // RULE1 RULE2
    clock_request_pin_hold)
    else $error("downstream port released clock request");

  a_cpm_down_zero: assert property (IS_DOWNSTREAM |-> !cpm_q) // RULE2
    else $error("downstream clock pm enable set");

  a_haw_write: assert property (wr_b1 |=> // RULE3
    haw_q == $past(cfg_wdata[plcs_pkg::HAW_DIS_BIT]))
    else $error("width disable not written");

  a_haw_steady: assert property (!wr_b1 |=> $stable(haw_q)) // RULE3
    else $error("width disable changed without write");

  a_haw_out: assert property (wr_b1 |=> // RULE3
    hw_width_disable == $past(cfg_wdata[plcs_pkg::HAW_DIS_BIT]))
    else $error("width disable output not updated");

  a_ie_up_ro: assert property (!IS_DOWNSTREAM |=> // RULE4
    $stable(bie_q) && $stable(aie_q))
    else $error("upstream interrupt enable changed");

  a_ie_up_zero: assert property (!IS_DOWNSTREAM |-> !bie_q && !aie_q) // RULE4
    else $error("upstream interrupt enable not zero");

  a_ie_down_wr: assert property (IS_DOWNSTREAM && wr_b1 |=> // RULE4
    bie_q == $past(cfg_wdata[plcs_pkg::BWM_IE_BIT]) &&
    aie_q == $past(cfg_wdata[plcs_pkg::ABW_IE_BIT]))
    else $error("downstream interrupt enable not written");

  a_rsvd_keep: assert property (!wr_b1 |=> $stable(rsvd_q)) // RULE5
    else $error("reserved bits changed without write");

  a_rsvd_write: assert property (wr_b1 |=> // RULE5
    rsvd_q == $past(cfg_wdata[plcs_pkg::RSVD_HI:plcs_pkg::RSVD_LO]))
    else $error("reserved bits not kept as written");

  a_speed_track: assert property (link_up |=> // RULE6 RULE7
    spd_q == $past(link_speed) && wid_q == $past(link_width))
    else $error("negotiated speed or width not captured");

  a_speed_hold: assert property (!link_up |=> $stable(spd_q)) // RULE6
    else $error("speed changed without link up");

  a_width_hold: assert property (!link_up |=> $stable(wid_q)) // RULE7
    else $error("width changed without link up");

  a_terr_set: assert property (train_fail |=> terr_q) // RULE8
    else $error("training error not set");

  a_terr_clr: assert property (train_l0 && !train_fail |=> !terr_q) // RULE8
    else $error("training error not cleared");

  a_terr_sticky: assert property (terr_q && !train_l0 |=> terr_q) // RULE8
    else $error("training error dropped before L0");

  a_train_flag: assert property (rst_n_q |=> // RULE9
    trn_q == $past(train_active))
    else $error("training flag wrong");

  a_train_begin: assert property (s_train_begin |=> trn_q) // RULE9
    else $error("training flag missed start");

  a_train_end: assert property (s_train_finish |=> !trn_q) // RULE9
    else $error("training flag not cleared at end");

  a_sclk_load: assert property (slot_clk_load |=> // RULE10
    sclk_q == $past(slot_clk_value))
    else $error("slot clock default not loaded");

  a_sclk_hold: assert property (!slot_clk_load |=> $stable(sclk_q)) // RULE10
    else $error("slot clock bit changed without load");

  a_dll_track: assert property (rst_n_q |=> // RULE11
    dll_q == $past(link_layer_active_state))
    else $error("link active bit wrong");

  a_dll_rise: assert property (s_dll_rise |=> dll_q) // RULE11
    else $error("link active bit missed rise");

  a_dll_fall: assert property (s_dll_fall |=> !dll_q) // RULE11
    else $error("link active bit missed fall");

  a_w1c_clear: assert property (s_mgmt_clear |=> !bst_q) // RULE12
    else $error("status not cleared by one");

  a_auto_clear: assert property (s_auto_clear |=> !ast_q) // RULE12
    else $error("autonomous status not cleared by one");

  a_w1c_set: assert property (bw_mgmt_event || bw_auto_event |=> // RULE12
    (bst_q || !$past(bw_mgmt_event)) && (ast_q || !$past(bw_auto_event)))
    else $error("status event lost");

  a_mgmt_keep: assert property (!bw_mgmt_event && // RULE12
    !(wr_b3 && cfg_wdata[plcs_pkg::BWM_ST_BIT]) |=> $stable(bst_q))
    else $error("management status changed on its own");

  a_auto_keep: assert property (!bw_auto_event && // RULE12
    !(wr_b3 && cfg_wdata[plcs_pkg::ABW_ST_BIT]) |=> $stable(ast_q))
    else $error("autonomous status changed on its own");

  a_read_word: assert property (s_status_read |=> // RULE6 RULE7
    cfg_rdata == $past(word))
    else $error("read data does not match register word");
endmodule

//--- verif/plcs_train_model.sv
// Behavioural link training partner that drives the training and link layer status inputs.
`timescale 1ns/1ps
module plcs_train_model (
  input wire logic clock, // Core clock.
  input wire logic start, // Begin one training attempt.
  input wire logic ok, // Attempt ends in L0 when high.
  output logic train_active, // Training in progress level.
  output logic train_l0, // Reached L0 pulse.
  output logic train_fail, // Training failed pulse.
  output logic link_up, // Negotiated values valid.
  output logic link_layer_active_state // Link layer active level.
);
  int n = 0;
  logic go = 1'b0;
  initial begin
    // Training is under way from power-up until the first attempt ends.
    {train_active, train_l0, train_fail} = 3'h4;
    {link_up, link_layer_active_state} = 2'h0;
  end
  // Start is taken on the rising edge and the outputs move on the falling
  // edge, so neither the bench nor the design is raced.
  always @(posedge clock) go <= start;
  always @(negedge clock) begin
    train_l0 <= (n == 1) && ok;
    train_fail <= (n == 1) && !ok;
    if (go) begin
      train_active <= 1'b1;
      link_up <= 1'b0;
      link_layer_active_state <= 1'b0;
      n <= 4;
    end else if (n == 1) begin
      train_active <= 1'b0;
      link_up <= ok;
      link_layer_active_state <= ok;
      n <= 0;
    end else if (n > 1) begin
      n <= n - 1;
    end
  end
endmodule

//--- verif/tb_plcs_regs.sv
// Self-checking bench for the link control and status register word.
`timescale 1ns/1ps
module tb_plcs_regs;
  logic clock = 0, resetn = 0, cfg_wr = 0, cfg_rd = 0, start = 0, ok = 0;
  logic [7:0] cfg_addr = 8'h00, a, cu = 8'h00, cd = 8'h00;
  logic [31:0] cfg_wdata = 0, cfg_rdata, dn_rdata, ru, rn, w, r;
  logic [3:0] cfg_be = 0, link_speed = 0, es = 4'h2;
  logic [5:0] link_width = 0, ew = 6'h04;
  logic bw_mgmt_event = 0, bw_auto_event = 0, sc = 1'b1;
  logic slot_clk_load = 0, slot_clk_value = 1, train_active, train_l0;
  logic train_fail, link_up, link_layer_active_state, dn_hold, dn_hwd;
  logic clock_request_pin_hold, hw_width_disable, bw_mgmt_int_en;
  logic bw_auto_int_en, dn_bwm, dn_abw;
  int seed = 32'h089ae991, fails = 0, check_count = 0, cyc = 0;
  always #2.5 clock = ~clock;
  plcs_regs u_plcs_regs (.*);
  plcs_regs #(.IS_DOWNSTREAM(1'b1)) u_plcs_regs_dn (.*,
    .cfg_rdata(dn_rdata), .clock_request_pin_hold(dn_hold),
    .hw_width_disable(dn_hwd), .bw_mgmt_int_en(dn_bwm),
    .bw_auto_int_en(dn_abw));
  plcs_train_model u_plcs_train_model (.*);
  function automatic logic [7:0] ctl(input logic [31:0] d, input bit dn);
    return {d[15:12], dn ? d[11:10] : 2'h0, d[9], dn ? 1'b0 : d[8]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [3:0] b,
                    input logic [31:0] d);
    @(negedge clock);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, ad, b, d};
    @(negedge clock);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(negedge clock);
    {cfg_rd, cfg_addr} = {1'b1, ad};
    @(negedge clock);
    cfg_rd = 1'b0;
    ru = cfg_rdata;
    rn = dn_rdata;
  endtask
  task automatic trn(input bit o);
    r = $random(seed);
    link_speed = r[4] ? plcs_pkg::SPEED_2G5 : plcs_pkg::SPEED_5G0;
    link_width = 6'h01 << r[6:5];
    @(negedge clock);
    {start, ok} = {1'b1, o};
    @(negedge clock);
    start = 1'b0;
    rd(8'hd0);
    chk({31'h0, ru[27]}, 32'h1);
    repeat (8) @(negedge clock);
    if (o) {es, ew} = {link_speed, link_width};
    rd(8'hd0);
    chk(ru, {2'h0, o, sc, 1'b0, !o, ew, es, cu, 8'h00});
    $display("training test done");
  endtask
  task automatic results;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    rd(8'hd0);
    chk(ru, 32'h1842_0000);
    chk(rn, 32'h1822_0000);
    $display("reset test done");
    // Random addresses reach unmapped space too, which must stay inert.
    for (int i = 0; i < 24; i++) begin
      w = (i == 0) ? 32'hffff_ffff : $random(seed);
      r = (i == 0) ? 32'h0000_0f80 : $random(seed);
      a = r[7] ? 8'hd0 : r[7:0];
      wr(a, r[11:8], w);
      if (a == 8'hd0 && r[9]) {cu, cd} = {ctl(w, 1'b0), ctl(w, 1'b1)};
      rd(8'hd0);
      chk({16'h0, ru[15:0]}, {16'h0, cu, 8'h00});
      chk({16'h0, rn[15:0]}, {16'h0, cd, 8'h00});
      chk({clock_request_pin_hold, hw_width_disable, bw_auto_int_en,
           bw_mgmt_int_en}, {!cu[0], cu[1], cu[3], cu[2]});
      chk({dn_hold, dn_hwd, dn_abw, dn_bwm},
          {!cd[0], cd[1], cd[3], cd[2]});
    end
    rd(8'h44);
    chk(ru, 32'h0);
    chk(rn, 32'h0);
    $display("control test done");
    @(negedge clock);
    {bw_mgmt_event, bw_auto_event} = 2'h3;
    @(negedge clock);
    {bw_mgmt_event, bw_auto_event} = 2'h0;
    rd(8'hd0);
    chk(ru[31:30], 2'h3);
    wr(8'hd0, 4'h8, 32'h4000_0000);
    wr(8'hd0, 4'h8, 32'h0);
    rd(8'hd0);
    chk(ru[31:30], 2'h2);
    wr(8'hd0, 4'h8, 32'h8000_0000);
    rd(8'hd0);
    chk(ru[31:30], 2'h0);
    // An event in the same cycle as its clear must survive the clear.
    @(negedge clock);
    {cfg_wr, cfg_addr, cfg_be} = {1'b1, 8'hd0, 4'h8};
    {cfg_wdata, bw_mgmt_event} = {32'hc000_0000, 1'b1};
    @(negedge clock);
    {cfg_wr, bw_mgmt_event} = 2'h0;
    rd(8'hd0);
    chk({rn[31:30], ru[31:30]}, 32'h5);
    wr(8'hd0, 4'h8, 32'h4000_0000);
    rd(8'hd0);
    chk({rn[31:30], ru[31:30]}, 32'h0);
    $display("status clear test done");
    trn(1'b0);
    trn(1'b1);
    @(negedge clock);
    {slot_clk_load, slot_clk_value} = 2'h2;
    @(negedge clock);
    {slot_clk_load, sc} = 2'h0;
    trn(1'b1);
    results();
  end
endmodule
